// file: src/sao_defs.svh
// constants for the synchronous analog output refresh block
`ifndef SAO_DEFS_SVH
`define SAO_DEFS_SVH
`define SAO_NCH 4
`define SAO_CHW 2
`define SAO_DW 16
`define SAO_SET_RST 16'h0000
`define SAO_EN_RST 4'hf
`define SAO_ONOFF_NS 1000
`define SAO_CLK_NS 8
`define SAO_ONOFF_CYC ((`SAO_ONOFF_NS + `SAO_CLK_NS - 1) / `SAO_CLK_NS)
`define SAO_DLYW 8
`endif

// file: src/sao_pkg.sv
// types for the synchronous analog output refresh block
`include "sao_defs.svh"
package sao_pkg;
	typedef logic [`SAO_DW-1:0] sao_word_t;
	typedef enum logic [1:0]
	{
		SAO_IDLE = 2'b00,
		SAO_CONV = 2'b01,
		SAO_WAIT = 2'b10
	} sao_state_e;
endpackage

// file: src/sao_refresh.sv
// synchronous analog output refresh: set value ports, conversion pass, timed apply
//
// Contract
// R1 - outputs of all synchronous modules update together on each distributed-clock sync event.
// R2 - set values arrive during each bus refresh, independent of the apply instant.
// R3 - one conversion pass is run per bus refresh cycle with that cycle's set values.
// R4 - the pass covers only enabled channels and results appear at the refresh instant.
// R5 - the apply instant keeps the sync period whatever the bus refresh jitter.
// R6 - a fixed on/off response delay separates the refresh instant from the terminal update.
// R7 - each channel has a read-write signed 16-bit set value port that resets to 0.
// R8 - a two-channel build exposes channels 1-2, a four-channel build channels 1-4.
// R9 - the host task period must exceed the bus refresh cycle or a warning is raised.
// R10 - the coupler must enable the distributed clock and list the modules first.
// R11 - the configurator derives sync period, refresh instant and max bus cycle.
// R12 - applied values hold between instants; new set values wait for the next instant.
`timescale 1ns/1ps
`include "sao_defs.svh"
module sao_refresh
#(
	parameter int NUM_CH = `SAO_NCH
)
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        dc_sync_event,
	input  wire logic        bus_refresh,
	input  wire logic        set_wr,
	input  wire logic [1:0]  set_ch,
	input  wire logic [15:0] set_wdata,
	input  wire logic [3:0]  chan_enable,
	output logic [15:0]      set_rdata,
	output logic [15:0]      channel1_output_setpoint,
	output logic [15:0]      channel2_output_setpoint,
	output logic [15:0]      channel3_output_setpoint,
	output logic [15:0]      channel4_output_setpoint,
	output logic [15:0]      dac_ch1,
	output logic [15:0]      dac_ch2,
	output logic [15:0]      dac_ch3,
	output logic [15:0]      dac_ch4,
	output logic             dac_load,
	output logic             term_update,
	output logic             conv_busy
);
	sao_pkg::sao_word_t   set_r    [`SAO_NCH];
	sao_pkg::sao_word_t   set_nxt  [`SAO_NCH];
	sao_pkg::sao_word_t   conv_r   [`SAO_NCH];
	sao_pkg::sao_word_t   conv_nxt [`SAO_NCH];
	sao_pkg::sao_word_t   out_r    [`SAO_NCH];
	sao_pkg::sao_word_t   out_nxt  [`SAO_NCH];
	sao_pkg::sao_state_e  st_r;
	sao_pkg::sao_state_e  st_nxt;
	logic [`SAO_CHW-1:0]  idx_r;
	logic [`SAO_CHW-1:0]  idx_nxt;
	logic [3:0]           en_r;
	logic [3:0]           en_nxt;
	logic [`SAO_DLYW-1:0] dly_r;
	logic [`SAO_DLYW-1:0] dly_nxt;
	logic                 dly_run_r;
	logic                 dly_run_nxt;
	logic                 load_nxt;
	logic                 upd_nxt;
	logic [15:0]          rdata_nxt;
	logic                 sync_p;
	logic [3:0]           avail;

	// channels present in this build
	function automatic logic [3:0] present_mask(input int n);
		logic [3:0] m;
		m = 4'h0;
		for (int i = 0; i < `SAO_NCH; i++)
			if (i < n)
				m[i] = 1'b1;
		return m;
	endfunction

	assign avail = present_mask(NUM_CH); // R8

	////////////////////////////////////////////////////////////////////////////
	// sync event through pin synchroniser
	sao_sync_in u_sync
	(
		.clk   (clk),
		.rst_b (rst_b),
		.din   (dc_sync_event),
		.rise  (sync_p)
	);

	////////////////////////////////////////////////////////////////////////////
	// set value ports
	always_comb
	begin
		set_nxt   = set_r;
		rdata_nxt = `SAO_SET_RST;
		if (set_wr && avail[set_ch]) // R8
			set_nxt[set_ch] = set_wdata; // R2 R7
		if (avail[set_ch])
			rdata_nxt = set_r[set_ch]; // R7
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < `SAO_NCH; i++)
				set_r[i] <= `SAO_SET_RST; // R7
			set_rdata <= `SAO_SET_RST;
		end
		else
		begin
			set_r     <= set_nxt;
			set_rdata <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// conversion pass, one per bus refresh, lowest channel first
	always_comb
	begin
		st_nxt   = st_r;
		idx_nxt  = idx_r;
		en_nxt   = en_r;
		conv_nxt = conv_r;
		out_nxt  = out_r;
		load_nxt = 1'b0;
		case (st_r)
			sao_pkg::SAO_IDLE:
			begin
				if (bus_refresh) // R3
				begin
					en_nxt  = chan_enable & avail; // R4
					idx_nxt = 2'h0;
					st_nxt  = sao_pkg::SAO_CONV;
				end
			end
			sao_pkg::SAO_CONV:
			begin
				if (en_r[idx_r])
					conv_nxt[idx_r] = set_r[idx_r]; // R3 R4
				if (idx_r == `SAO_CHW'(`SAO_NCH - 1))
					st_nxt = sao_pkg::SAO_WAIT;
				else
					idx_nxt = idx_r + 2'h1;
			end
			sao_pkg::SAO_WAIT:
			begin
				if (bus_refresh)
				begin
					en_nxt  = chan_enable & avail;
					idx_nxt = 2'h0;
					st_nxt  = sao_pkg::SAO_CONV; // R3
				end
			end
			default:
				st_nxt = sao_pkg::SAO_IDLE;
		endcase
		if (sync_p) // R1 R5
		begin
			for (int i = 0; i < `SAO_NCH; i++)
				if (en_r[i])
					out_nxt[i] = conv_r[i]; // R4 R12
			load_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_r     <= sao_pkg::SAO_IDLE;
			idx_r    <= 2'h0;
			en_r     <= 4'h0;
			dac_load <= 1'b0;
			for (int i = 0; i < `SAO_NCH; i++)
			begin
				conv_r[i] <= `SAO_SET_RST;
				out_r[i]  <= `SAO_SET_RST;
			end
		end
		else
		begin
			st_r     <= st_nxt;
			idx_r    <= idx_nxt;
			en_r     <= en_nxt;
			conv_r   <= conv_nxt;
			out_r    <= out_nxt; // R12
			dac_load <= load_nxt; // R1
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// on/off response delay to terminal update
	always_comb
	begin
		dly_nxt     = dly_r;
		dly_run_nxt = dly_run_r;
		upd_nxt     = 1'b0;
		if (load_nxt)
		begin
			dly_nxt     = `SAO_DLYW'(`SAO_ONOFF_CYC - 1); // R6
			dly_run_nxt = 1'b1;
		end
		else if (dly_run_r)
		begin
			if (dly_r == 0)
			begin
				dly_run_nxt = 1'b0;
				upd_nxt     = 1'b1; // R6
			end
			else
				dly_nxt = dly_r - `SAO_DLYW'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			dly_r       <= '0;
			dly_run_r   <= 1'b0;
			term_update <= 1'b0;
		end
		else
		begin
			dly_r       <= dly_nxt;
			dly_run_r   <= dly_run_nxt;
			term_update <= upd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered output copies
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			channel1_output_setpoint <= `SAO_SET_RST;
			channel2_output_setpoint <= `SAO_SET_RST;
			channel3_output_setpoint <= `SAO_SET_RST;
			channel4_output_setpoint <= `SAO_SET_RST;
			dac_ch1   <= `SAO_SET_RST;
			dac_ch2   <= `SAO_SET_RST;
			dac_ch3   <= `SAO_SET_RST;
			dac_ch4   <= `SAO_SET_RST;
			conv_busy <= 1'b0;
		end
		else
		begin
			channel1_output_setpoint <= set_nxt[0];
			channel2_output_setpoint <= set_nxt[1];
			channel3_output_setpoint <= set_nxt[2];
			channel4_output_setpoint <= set_nxt[3];
			dac_ch1   <= out_nxt[0]; // R12
			dac_ch2   <= out_nxt[1];
			dac_ch3   <= out_nxt[2];
			dac_ch4   <= out_nxt[3];
			conv_busy <= (st_nxt == sao_pkg::SAO_CONV);
		end
	end
endmodule

// file: src/sao_sync_in.sv
// three-stage synchroniser with second/third agreement and rising-edge pulse
`timescale 1ns/1ps
`include "sao_defs.svh"
module sao_sync_in
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic din,
	output logic      rise
);
	logic [2:0] sh_r;
	logic [2:0] sh_nxt;
	logic       lvl_r;
	logic       lvl_nxt;
	logic       rise_nxt;

	always_comb
	begin
		sh_nxt   = {sh_r[1:0], din};
		lvl_nxt  = lvl_r;
		rise_nxt = 1'b0;
		if (sh_r[1] == sh_r[2])
		begin
			lvl_nxt  = sh_r[2];
			rise_nxt = sh_r[2] & ~lvl_r;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sh_r  <= 3'h0;
			lvl_r <= 1'b0;
			rise  <= 1'b0;
		end
		else
		begin
			sh_r  <= sh_nxt;
			lvl_r <= lvl_nxt;
			rise  <= rise_nxt;
		end
	end
endmodule

// file: tb/sao_coupler_model.sv
// coupler model driving the local unit bus
`timescale 1ns/1ps
module sao_coupler_model
(
	input  wire logic        clk,
	input  wire logic [15:0] set_rdata,
	output logic             bus_refresh,
	output logic             set_wr,
	output logic [1:0]       set_ch,
	output logic [15:0]      set_wdata,
	output logic             dc_sync_event
);
	initial
	begin
		bus_refresh = 1'b0;
		set_wr = 1'b0;
		set_ch = 2'h0;
		set_wdata = 16'h0;
		dc_sync_event = 1'b0;
	end
	////////////////
	task automatic wr(input logic [1:0] c, input logic [15:0] d);
		@(negedge clk);
		set_ch = c;
		set_wdata = d;
		set_wr = 1'b1;
		@(negedge clk);
		set_wr = 1'b0;
		set_wdata = ~d;
	endtask
	task automatic rd(input logic [1:0] c, output logic [15:0] d);
		@(negedge clk);
		set_ch = c;
		@(negedge clk);
		d = set_rdata;
	endtask
	task automatic refresh();
		@(negedge clk);
		bus_refresh = 1'b1;
		@(negedge clk);
		bus_refresh = 1'b0;
		repeat (6) @(negedge clk);
	endtask
	task automatic sy(input logic v);
		@(negedge clk);
		dc_sync_event = v;
	endtask
endmodule

// file: tb/sao_refresh_monitor.sv
// assertions on the refresh block ports
`timescale 1ns/1ps
module sao_refresh_monitor
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        dc_sync_event,
	input wire logic        bus_refresh,
	input wire logic        set_wr,
	input wire logic [1:0]  set_ch,
	input wire logic [15:0] set_wdata,
	input wire logic [15:0] set_rdata,
	input wire logic [15:0] channel1_output_setpoint,
	input wire logic [15:0] dac_ch1,
	input wire logic        dac_load,
	input wire logic        term_update,
	input wire logic        conv_busy
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	////////////////
	sync_apply_a: assert property ($rose(dc_sync_event) |-> ##[3:6] dac_load)
		else $error("no apply after sync");
	term_delay_a: assert property ($rose(dac_load) |-> ##125 term_update)
		else $error("term update late");
	dac_hold_a: assert property ($changed(dac_ch1) |-> dac_load)
		else $error("dac moved off refresh");
	pass_len_a: assert property ($rose(conv_busy) |-> conv_busy[*4] ##1 !conv_busy)
		else $error("pass length wrong");
	pass_start_a: assert property (bus_refresh && !conv_busy |=> conv_busy)
		else $error("pass not started");
	setpt_write_a: assert property (set_wr && set_ch == 2'h0 |=>
		channel1_output_setpoint == $past(set_wdata)) else $error("set value lost");
	setpt_read_a: assert property (set_ch == 2'h0 |=>
		set_rdata == $past(channel1_output_setpoint)) else $error("read back wrong");
	reset_zero_a: assert property ($rose(rst_b) |-> dac_ch1 == 16'h0)
		else $error("dac not cleared");
	cover property (dac_load);
	cover property (term_update);
	cover property (conv_busy);
endmodule
bind sao_refresh sao_refresh_monitor mon (.clk, .rst_b, .dc_sync_event, .bus_refresh, .set_wr,
	.set_ch, .set_wdata, .set_rdata, .channel1_output_setpoint, .dac_ch1, .dac_load,
	.term_update, .conv_busy);

// file: tb/tb.sv
// testbench for the synchronous analog output refresh block
`timescale 1ns/1ps
module tb;
	logic        clk, rst_b, bus_refresh, set_wr, dc_sync_event, dac_load, term_update;
	logic [3:0]  chan_enable;
	logic [1:0]  set_ch;
	logic [15:0] set_wdata, set_rdata, c1, c2, c3, c4, d1, d2, d3, d4, v;
	logic [15:0] r2, e3, e4, f3, f4;
	logic [15:0] vals [4] = '{16'h7fff, 16'h8000, 16'h1234, 16'hfffe};
	int          error_cnt, comparisons, i, n;
	always #4 clk = ~clk;
	sao_refresh dut (.clk, .rst_b, .dc_sync_event, .bus_refresh, .set_wr, .set_ch, .set_wdata,
		.chan_enable, .set_rdata, .channel1_output_setpoint(c1), .channel2_output_setpoint(c2),
		.channel3_output_setpoint(c3), .channel4_output_setpoint(c4), .dac_ch1(d1),
		.dac_ch2(d2), .dac_ch3(d3), .dac_ch4(d4), .dac_load, .term_update, .conv_busy());
	sao_refresh #(.NUM_CH(2)) dut2 (.clk, .rst_b, .dc_sync_event, .bus_refresh, .set_wr,
		.set_ch, .set_wdata, .chan_enable, .set_rdata(r2), .channel1_output_setpoint(),
		.channel2_output_setpoint(), .channel3_output_setpoint(e3),
		.channel4_output_setpoint(e4), .dac_ch1(), .dac_ch2(), .dac_ch3(f3), .dac_ch4(f4),
		.dac_load(), .term_update(), .conv_busy());
	sao_coupler_model cpl (.clk, .set_rdata, .bus_refresh, .set_wr, .set_ch, .set_wdata,
		.dc_sync_event);
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wt(input bit s);
		for (n = 1; n < 200; n++)
		begin
			@(negedge clk);
			if ((s ? term_update : dac_load) === 1'b1)
				return;
		end
		chk("wait", 16'h0, 16'h1);
		end_sim();
	endtask
	////////////////
	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		chan_enable = 4'hf;
		error_cnt = 0;
		comparisons = 0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		for (i = 0; i < 4; i++)
		begin
			cpl.rd(i[1:0], v);
			chk("set_rst", 16'h0, v);
			cpl.wr(i[1:0], vals[i]);
			cpl.rd(i[1:0], v);
			chk("set_rd", vals[i], v);
			chk("set_rd_2ch", (i < 2) ? vals[i] : 16'h0, r2);
		end
		chk("ch1_port", vals[0], c1);
		chk("ch2_port", vals[1], c2);
		chk("ch3_port", vals[2], c3);
		chk("ch4_port", vals[3], c4);
		chk("ch3_port_2ch", 16'h0, e3);
		chk("ch4_port_2ch", 16'h0, e4);
		chan_enable = 4'hb;
		cpl.refresh();
		chk("dac_hold", 16'h0, d1);
		cpl.sy(1'b1);
		wt(1'b0);
		chk("dac1", vals[0], d1);
		chk("dac2", vals[1], d2);
		chk("dac3_off", 16'h0, d3);
		chk("dac4", vals[3], d4);
		wt(1'b1);
		chk("term_dly", 16'h007d, n[15:0]);
		cpl.sy(1'b0);
		cpl.wr(2'h0, 16'h8001);
		chan_enable = 4'hf;
		cpl.refresh();
		chk("dac_keep", vals[0], d1);
		cpl.sy(1'b1);
		wt(1'b0);
		chk("dac1_new", 16'h8001, d1);
		chk("dac2_keep", vals[1], d2);
		chk("dac3_on", vals[2], d3);
		chk("dac4_keep", vals[3], d4);
		chk("dac3_2ch", 16'h0, f3);
		chk("dac4_2ch", 16'h0, f4);
		wt(1'b1);
		cpl.sy(1'b0);
		end_sim();
	end
endmodule
